// File: rtl/dtc_pkg.sv
// package: register map, field codes and timing constants of the drive control core
package dtc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_TORQ_CFG   = 8'h00;
    localparam logic [7:0] OFS_TORQ_DLY   = 8'h04;
    localparam logic [7:0] OFS_RELAY_CFG  = 8'h08;
    localparam logic [7:0] OFS_VF_CFG     = 8'h0c;
    localparam logic [7:0] OFS_VF_PTS     = 8'h10;
    localparam logic [7:0] OFS_SLIP_CFG   = 8'h14;
    localparam logic [7:0] OFS_PID_CFG    = 8'h18;
    localparam logic [7:0] OFS_PID_GAIN   = 8'h1c;
    localparam logic [7:0] OFS_PID_TIME   = 8'h20;
    localparam logic [7:0] OFS_STATUS     = 8'h24;
    localparam logic [7:0] OFS_VF_OUT     = 8'h28;
    localparam logic [7:0] OFS_PID_OUT    = 8'h2c;
    // selection codes
    localparam logic [3:0] DET_OFF        = 4'h0;
    localparam logic [3:0] DET_AT_SPEED   = 4'h1;
    localparam logic [3:0] DET_RUN        = 4'h2;
    localparam logic [3:0] ACT_CONTINUE   = 4'h0;
    localparam logic [3:0] ACT_COAST      = 4'h1;
    localparam logic [3:0] RLY_OVER       = 4'h5;
    localparam logic [3:0] RLY_UNDER      = 4'hf;
    localparam logic [4:0] VF_CUSTOM      = 5'h12;
    localparam logic [4:0] VF_60HZ_FIRST  = 5'h09;
    localparam logic [4:0] VF_LAST        = 5'h11;
    localparam logic [7:0] AIN_PID_FB     = 8'h14;
    localparam logic [3:0] FBD_PID        = 4'h1;
    localparam logic [3:0] METER_PID_FB   = 4'h5;
    localparam logic [8:0] OFFSET_MAX     = 9'h06d;
    localparam logic [8:0] BOOST_MAX      = 9'h12c;
    // timing: delays count in 0.1 s ticks
    localparam int         CLK_MHZ        = 250;
    localparam int         TICK_MS        = 100;
    localparam int         TICK_CYC       = CLK_MHZ * 1000 * TICK_MS;
    // b and c percentages in 0.1 % of the nine 50 hz and 60 hz presets
    typedef struct packed {
        logic [9:0] b;
        logic [9:0] c;
    } dtc_vf_pt_s;
    typedef struct packed {
        logic over;
        logic under;
        logic over_flash;
        logic under_flash;
        logic tripped;
    } dtc_torq_s;
endpackage

// File: rtl/dtc_core.sv
// drive control core: torque supervisor, v/f pattern and pid, apb registers
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
module dtc_core #(
    parameter int TICK_CYCLES = dtc_pkg::TICK_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [8:0]  torque_pct,
    input  wire logic [15:0] out_current,
    input  wire logic        run_mode,
    input  wire logic        at_set_freq,
    input  wire logic        fault_reset,
    input  wire logic [15:0] freq_command,
    input  wire logic [15:0] pid_feedback,
    output logic             coast_stop,
    output logic             relay1_out,
    output logic             relay2_out,
    output logic             over_torque_code,
    output logic             under_torque_code,
    output logic [9:0]       vf_b_pct,
    output logic [9:0]       vf_c_pct,
    output logic [9:0]       vf_boost_pct,
    output logic [15:0]      slip_freq,
    output logic [15:0]      pid_freq_out,
    output logic [15:0]      keypad_value,
    output logic [15:0]      analog_meter_output
);
    // configuration registers
    logic [31:0] torq_cfg_reg, torq_dly_reg, relay_cfg_reg, vf_cfg_reg;
    logic [31:0] vf_pts_reg, slip_cfg_reg, pid_cfg_reg, pid_gain_reg, pid_time_reg;
    logic [31:0] rd_mux;
    logic        rs_s1, rs_s2, run_s1, run_s2, at_s1, at_s2;

    wire       wr_en = psel && penable && pwrite;
    wire [3:0] torque_detect_select  = torq_cfg_reg[3:0];
    wire [3:0] torque_fault_action   = torq_cfg_reg[7:4];
    wire [8:0] over_torque_threshold = torq_cfg_reg[16:8];
    wire [8:0] under_torque_threshold = torq_cfg_reg[25:17];
    wire [7:0] over_torque_delay     = torq_dly_reg[7:0];
    wire [7:0] under_torque_delay    = torq_dly_reg[15:8];
    wire [3:0] relay1_function       = relay_cfg_reg[3:0];
    wire [3:0] relay2_function       = relay_cfg_reg[7:4];
    wire [3:0] feedback_display_select = relay_cfg_reg[11:8];
    wire [3:0] meter_output_function = relay_cfg_reg[15:12];
    wire [7:0] analog_input_function = relay_cfg_reg[23:16];
    wire [4:0] vf_pattern_select     = vf_cfg_reg[4:0];
    wire [8:0] torque_boost_gain     = vf_cfg_reg[16:8];
    wire [9:0] vf_max_volt_ratio     = vf_pts_reg[9:0];
    wire [9:0] vf_mid_volt_ratio     = vf_pts_reg[19:10];
    wire [9:0] vf_min_volt_ratio     = vf_pts_reg[29:20];
    wire [15:0] no_load_current      = slip_cfg_reg[15:0];
    wire [15:0] motor_rated_current  = {8'h00, slip_cfg_reg[31:24]} << 4;
    wire [9:0] rated_slip_comp       = {2'b00, slip_cfg_reg[23:16]};
    wire [3:0] pid_mode_select       = pid_cfg_reg[3:0];
    wire       pid_offset_sign       = pid_cfg_reg[4];
    wire [8:0] pid_offset_level      = pid_cfg_reg[16:8];
    wire [7:0] output_lag_time       = pid_cfg_reg[31:24];
    wire [9:0] feedback_cal_gain     = pid_gain_reg[9:0];
    wire [9:0] prop_gain             = pid_gain_reg[25:16];
    wire [9:0] integral_time         = pid_time_reg[9:0];
    wire [9:0] differential_time     = pid_time_reg[25:16];

    // synchronisers for pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rs_s1, rs_s2, run_s1, run_s2, at_s1, at_s2} <= 6'h00;
        end else begin
            {rs_s1, run_s1, at_s1} <= {fault_reset, run_mode, at_set_freq};
            {rs_s2, run_s2, at_s2} <= {rs_s1, run_s1, at_s1};
        end
    end

    // apb register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            torq_cfg_reg  <= 32'h0;
            torq_dly_reg  <= 32'h0;
            relay_cfg_reg <= 32'h0;
            vf_cfg_reg    <= 32'h0;
            vf_pts_reg    <= 32'h0;
            slip_cfg_reg  <= 32'h0;
            pid_cfg_reg   <= 32'h0;
            pid_gain_reg  <= 32'h0;
            pid_time_reg  <= 32'h0;
        end else if (wr_en) begin
            case (paddr)
                dtc_pkg::OFS_TORQ_CFG:  torq_cfg_reg  <= pwdata;
                dtc_pkg::OFS_TORQ_DLY:  torq_dly_reg  <= pwdata;
                dtc_pkg::OFS_RELAY_CFG: relay_cfg_reg <= pwdata;
                dtc_pkg::OFS_VF_CFG:    vf_cfg_reg    <= pwdata;
                dtc_pkg::OFS_VF_PTS:    vf_pts_reg    <= pwdata;
                dtc_pkg::OFS_SLIP_CFG:  slip_cfg_reg  <= pwdata;
                dtc_pkg::OFS_PID_CFG:   pid_cfg_reg   <= pwdata;
                dtc_pkg::OFS_PID_GAIN:  pid_gain_reg  <= pwdata;
                dtc_pkg::OFS_PID_TIME:  pid_time_reg  <= pwdata;
                default: ;
            endcase
        end
    end

    // 0.1 s tick
    logic [31:0] tick_cnt_reg;
    wire         tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tick_cnt_reg <= 32'h0;
        else          tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
    end

    // torque supervisor
    wire det_on = (torque_detect_select == dtc_pkg::DET_RUN && run_s2) ||
                  (torque_detect_select == dtc_pkg::DET_AT_SPEED && run_s2 && at_s2);
    wire over_lvl  = det_on && (torque_pct > over_torque_threshold);
    wire under_lvl = det_on && (torque_pct < under_torque_threshold);
    logic [7:0] over_cnt_reg, under_cnt_reg;
    logic       over_reg, under_reg, trip_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_cnt_reg  <= 8'h0;
            under_cnt_reg <= 8'h0;
            over_reg      <= 1'b0;
            under_reg     <= 1'b0;
        end else begin
            if (!over_lvl) over_cnt_reg <= 8'h0;
            else if (tick && over_cnt_reg <= over_torque_delay) over_cnt_reg <= over_cnt_reg + 8'h1;
            if (!under_lvl) under_cnt_reg <= 8'h0;
            else if (tick && under_cnt_reg <= under_torque_delay)
                under_cnt_reg <= under_cnt_reg + 8'h1;
            over_reg  <= over_lvl && (over_cnt_reg > over_torque_delay);
            under_reg <= under_lvl && (under_cnt_reg > under_torque_delay);
        end
    end

    // latched trip: set wins over reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) trip_reg <= 1'b0;
        else if ((over_reg || under_reg) && torque_fault_action == dtc_pkg::ACT_COAST)
            trip_reg <= 1'b1;
        else if (rs_s2) trip_reg <= 1'b0;
    end
    logic trip_over_reg, trip_under_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_over_reg  <= 1'b0;
            trip_under_reg <= 1'b0;
        end else if (!trip_reg) begin
            trip_over_reg  <= over_reg;
            trip_under_reg <= under_reg;
        end
    end
    assign coast_stop        = trip_reg;
    assign over_torque_code  = over_reg || (trip_reg && trip_over_reg);
    assign under_torque_code = under_reg || (trip_reg && trip_under_reg);
    assign relay1_out = (relay1_function == dtc_pkg::RLY_OVER && over_reg) ||
                        (relay1_function == dtc_pkg::RLY_UNDER && under_reg);
    assign relay2_out = (relay2_function == dtc_pkg::RLY_OVER && over_reg) ||
                        (relay2_function == dtc_pkg::RLY_UNDER && under_reg);

    // v/f pattern: preset table in 0.1 %
    localparam dtc_pkg::dtc_vf_pt_s VF50 [9] = '{
        '{10'd75, 10'd45}, '{10'd100, 10'd70}, '{10'd110, 10'd85}, '{10'd120, 10'd95},
        '{10'd175, 10'd40}, '{10'd250, 10'd50}, '{10'd450, 10'd10}, '{10'd550, 10'd10},
        '{10'd650, 10'd10}};
    localparam dtc_pkg::dtc_vf_pt_s VF60 [9] = '{
        '{10'd75, 10'd45}, '{10'd100, 10'd70}, '{10'd110, 10'd80}, '{10'd120, 10'd90},
        '{10'd205, 10'd70}, '{10'd285, 10'd80}, '{10'd450, 10'd10}, '{10'd550, 10'd10},
        '{10'd650, 10'd10}};
    wire       is60   = vf_pattern_select >= dtc_pkg::VF_60HZ_FIRST;
    wire [4:0] vf_idx = is60 ? vf_pattern_select - dtc_pkg::VF_60HZ_FIRST : vf_pattern_select;
    wire dtc_pkg::dtc_vf_pt_s preset = (vf_idx > 5'd8) ? '0 : (is60 ? VF60[vf_idx[3:0]]
                                                             : VF50[vf_idx[3:0]]);
    wire [8:0] boost_lim = (torque_boost_gain > dtc_pkg::BOOST_MAX) ? dtc_pkg::BOOST_MAX
                                                                      : torque_boost_gain;
    wire [31:0] slip_num = (out_current > no_load_current) ?
                           32'(out_current - no_load_current) * 32'(rated_slip_comp) : 32'h0;
    wire [15:0] slip_den = (motor_rated_current > no_load_current) ?
                           motor_rated_current - no_load_current : 16'h1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vf_b_pct     <= 10'h0;
            vf_c_pct     <= 10'h0;
            vf_boost_pct <= 10'h0;
            slip_freq    <= 16'h0;
        end else begin
            if (vf_pattern_select == dtc_pkg::VF_CUSTOM) begin
                vf_b_pct <= vf_mid_volt_ratio;
                vf_c_pct <= vf_min_volt_ratio;
            end else begin
                vf_b_pct <= preset.b;
                vf_c_pct <= preset.c;
            end
            vf_boost_pct <= {1'b0, boost_lim};
            slip_freq    <= 16'(slip_num / 32'(slip_den));
        end
    end

    // pid controller, q7 fixed point gains
    wire        pid_on  = (pid_mode_select != 4'h0) && (pid_mode_select <= 4'h8) &&
                          (analog_input_function == dtc_pkg::AIN_PID_FB);
    wire [3:0]  base    = (pid_mode_select > 4'h4) ? pid_mode_select - 4'h4 : pid_mode_select;
    wire        use_fb  = (base == 4'h2) || (base == 4'h4);
    wire        rev     = (base >= 4'h3);
    wire        add_cmd = pid_mode_select >= 4'h5;
    wire signed [31:0] dev = ((32'(signed'({1'b0, freq_command})) -
                               32'(signed'({1'b0, pid_feedback}))) *
                              32'(signed'({1'b0, feedback_cal_gain}))) >>> 7;
    logic signed [31:0] integ_reg, prev_reg;
    wire signed [31:0] dsrc = use_fb ? -32'(signed'({1'b0, pid_feedback})) : dev;
    wire signed [31:0] p_t  = (dev * 32'(signed'({1'b0, prop_gain}))) >>> 7;
    wire signed [31:0] d_t  = ((dsrc - prev_reg) * 32'(signed'({1'b0, differential_time}))) >>> 7;
    wire signed [31:0] i_n  = (integral_time == 10'h0) ? 32'sh0 :
                              integ_reg + dev / 32'(signed'({1'b0, integral_time}));
    wire signed [31:0] ofs  = pid_offset_sign ? -32'(signed'({23'h0, pid_offset_level}))
                                              : 32'(signed'({23'h0, pid_offset_level}));
    wire signed [31:0] sum0 = p_t + i_n + d_t;
    wire signed [31:0] sum1 = (rev ? -sum0 : sum0) + ofs +
                              (add_cmd ? 32'(signed'({1'b0, freq_command})) : 32'sh0);
    logic [7:0] lag_cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            integ_reg    <= 32'sh0;
            prev_reg     <= 32'sh0;
            lag_cnt_reg  <= 8'h0;
            pid_freq_out <= 16'h0;
        end else if (!pid_on) begin
            integ_reg    <= 32'sh0;
            prev_reg     <= 32'sh0;
            pid_freq_out <= freq_command;
        end else if (tick) begin
            integ_reg <= i_n;
            prev_reg  <= dsrc;
            if (lag_cnt_reg >= output_lag_time) begin
                lag_cnt_reg  <= 8'h0;
                pid_freq_out <= sum1[31] ? 16'h0 : (|sum1[30:16] ? 16'hffff : sum1[15:0]);
            end else begin
                lag_cnt_reg <= lag_cnt_reg + 8'h1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keypad_value        <= 16'h0;
            analog_meter_output <= 16'h0;
        end else begin
            keypad_value <= (feedback_display_select == dtc_pkg::FBD_PID) ?
                            pid_feedback : pid_freq_out;
            analog_meter_output <= (meter_output_function == dtc_pkg::METER_PID_FB) ?
                                   pid_feedback : pid_freq_out;
        end
    end

    // apb read
    wire [31:0] status = {27'h0, trip_reg, under_reg, over_reg, under_lvl, over_lvl};
    always_comb begin
        case (paddr)
            dtc_pkg::OFS_TORQ_CFG:  rd_mux = torq_cfg_reg;
            dtc_pkg::OFS_TORQ_DLY:  rd_mux = torq_dly_reg;
            dtc_pkg::OFS_RELAY_CFG: rd_mux = relay_cfg_reg;
            dtc_pkg::OFS_VF_CFG:    rd_mux = vf_cfg_reg;
            dtc_pkg::OFS_VF_PTS:    rd_mux = vf_pts_reg;
            dtc_pkg::OFS_SLIP_CFG:  rd_mux = slip_cfg_reg;
            dtc_pkg::OFS_PID_CFG:   rd_mux = pid_cfg_reg;
            dtc_pkg::OFS_PID_GAIN:  rd_mux = pid_gain_reg;
            dtc_pkg::OFS_PID_TIME:  rd_mux = pid_time_reg;
            dtc_pkg::OFS_STATUS:    rd_mux = status;
            dtc_pkg::OFS_VF_OUT:    rd_mux = {6'h0, vf_c_pct, 6'h0, vf_b_pct};
            dtc_pkg::OFS_PID_OUT:   rd_mux = {16'h0, pid_freq_out};
            default:                rd_mux = 32'h0;
        endcase
    end
    assign prdata  = rd_mux;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // assertions
    property p_relay_over;
        @(posedge pclk) disable iff (!presetn)
        (relay1_function == dtc_pkg::RLY_OVER && over_reg) |-> relay1_out;
    endproperty
    a_relay_over: assert property (p_relay_over) else $error("relay1 not on over");
    property p_relay_under;
        @(posedge pclk) disable iff (!presetn)
        (relay2_function == dtc_pkg::RLY_UNDER && under_reg) |-> relay2_out;
    endproperty
    a_relay_under: assert property (p_relay_under) else $error("relay2 not on under");
    property p_det_off;
        @(posedge pclk) disable iff (!presetn)
        (torque_detect_select == dtc_pkg::DET_OFF) [*2] |-> !over_reg && !under_reg;
    endproperty
    a_det_off: assert property (p_det_off) else $error("detection while disabled");
    property p_over_cause;
        @(posedge pclk) disable iff (!presetn)
        $rose(over_reg) |-> $past(over_cnt_reg) > over_torque_delay;
    endproperty
    a_over_cause: assert property (p_over_cause) else $error("over early");
    property p_under_cause;
        @(posedge pclk) disable iff (!presetn)
        $rose(under_reg) |-> $past(under_cnt_reg) > under_torque_delay;
    endproperty
    a_under_cause: assert property (p_under_cause) else $error("under early");
    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        !over_lvl |=> over_cnt_reg == 8'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("timer kept");
    property p_trip_hold;
        @(posedge pclk) disable iff (!presetn)
        (coast_stop && !rs_s2) |=> coast_stop;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip lost");
    property p_no_trip_cont;
        @(posedge pclk) disable iff (!presetn)
        (torque_fault_action == dtc_pkg::ACT_CONTINUE && !coast_stop) [*2] |=> !coast_stop;
    endproperty
    a_no_trip_cont: assert property (p_no_trip_cont) else $error("tripped on continue");
    property p_pid_off;
        @(posedge pclk) disable iff (!presetn)
        !pid_on |=> pid_freq_out == $past(freq_command);
    endproperty
    a_pid_off: assert property (p_pid_off) else $error("pid active while off");
endmodule // dtc_core

// File: bench/dtc_motor_model.sv
// motor and process side model driving the torque and run status inputs
`timescale 1ns/1ps
module dtc_motor_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        coast_stop,
    input  wire logic        run_cmd,
    input  wire logic        speed_ok,
    input  wire logic [8:0]  load_pct,
    output logic      [8:0]  torque_pct,
    output logic      [15:0] out_current,
    output logic             run_mode,
    output logic             at_set_freq
);
    // a coasting motor makes no torque and runs again once coast_stop clears while run_cmd is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_mode    <= 1'b0;
            at_set_freq <= 1'b0;
            torque_pct  <= 9'h000;
        end else begin
            run_mode    <= run_cmd & ~coast_stop;
            at_set_freq <= run_mode & speed_ok;
            torque_pct  <= run_mode ? load_pct : 9'h000;
        end
    end
    assign out_current = {7'h00, torque_pct};
endmodule // dtc_motor_model

// File: bench/dtc_core_tb_top.sv
// self-checking bench of the drive control core
`timescale 1ns/1ps
module dtc_core_tb_top;
    localparam logic [9:0] PB [18] = '{10'h04b, 10'h064, 10'h06e, 10'h078, 10'h0af, 10'h0fa,
        10'h1c2, 10'h226, 10'h28a, 10'h04b, 10'h064, 10'h06e, 10'h078, 10'h0cd, 10'h11d,
        10'h1c2, 10'h226, 10'h28a};
    localparam logic [9:0] PC [18] = '{10'h02d, 10'h046, 10'h055, 10'h05f, 10'h028, 10'h032,
        10'h00a, 10'h00a, 10'h00a, 10'h02d, 10'h046, 10'h050, 10'h05a, 10'h046, 10'h050,
        10'h00a, 10'h00a, 10'h00a};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        run_mode, at_set_freq, fault_reset, coast_stop, relay1_out, relay2_out;
    logic        over_c, under_c, run_cmd, speed_ok;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [8:0]  torque_pct, load, bst;
    logic [15:0] out_current, freq_command, pid_feedback, slip_freq, pid_freq_out, kv, meter;
    logic [9:0]  vb, vc, vbst;
    int          num_errors, samples_checked;

    dtc_core #(.TICK_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .torque_pct(torque_pct), .out_current(out_current),
        .run_mode(run_mode), .at_set_freq(at_set_freq), .fault_reset(fault_reset),
        .freq_command(freq_command), .pid_feedback(pid_feedback), .coast_stop(coast_stop),
        .relay1_out(relay1_out), .relay2_out(relay2_out), .over_torque_code(over_c),
        .under_torque_code(under_c), .vf_b_pct(vb), .vf_c_pct(vc), .vf_boost_pct(vbst),
        .slip_freq(slip_freq), .pid_freq_out(pid_freq_out), .keypad_value(kv),
        .analog_meter_output(meter));
    dtc_motor_model i_motor (.pclk(pclk), .presetn(presetn), .coast_stop(coast_stop),
        .run_cmd(run_cmd), .speed_ok(speed_ok), .load_pct(load), .torque_pct(torque_pct),
        .out_current(out_current), .run_mode(run_mode), .at_set_freq(at_set_freq));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] tc(input logic [3:0] d, input logic [3:0] a);
        return {6'h00, 9'h064, 9'h096, a, d};
    endfunction
    function automatic logic [15:0] slip(input int cur, input int nl, input int rt, input int s);
        return 16'((cur - nl) * s / (rt - nl));
    endfunction
    // unity cal gain, p gain 2.0, offset 100; k 0 mode 1, k 1 mode 7 negative, k 2-3 off
    function automatic logic [31:0] pid_exp(input int k, input int cmd, input int fb);
        int r = 2 * (cmd - fb);
        return (k > 1) ? cmd : (k == 1) ? cmd - r - 100 : r + 100;
    endfunction
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, fault_reset, run_cmd, speed_ok} = 7'h00;
        {paddr, pwdata, load, freq_command, pid_feedback} = '0;
        void'($urandom(32'h966c));
        wt(10);
        presetn <= 1'b1;
        apb(dtc_pkg::OFS_TORQ_CFG, 1'b0, 32'h0);
        chk(q, 32'h0);
        apb(8'h30, 1'b1, 32'hffffffff);
        apb(8'h30, 1'b0, 32'h0);
        chk(q, 32'h0);
        chk({pready, pslverr}, 32'h2);
        apb(dtc_pkg::OFS_RELAY_CFG, 1'b1, 32'h001451f5);
        apb(dtc_pkg::OFS_TORQ_DLY, 1'b1, 32'h00000102);
        run_cmd <= 1'b1;
        speed_ok <= 1'b1;
        load <= 9'h0b4;
        wt(60);
        chk({over_c, relay1_out}, 32'h0);
        apb(dtc_pkg::OFS_TORQ_CFG, 1'b1, tc(dtc_pkg::DET_RUN, dtc_pkg::ACT_CONTINUE));
        repeat (40) begin
            load <= 9'(101 + $urandom % 49);
            pid_feedback <= 16'($urandom);
            wt(1);
        end
        wt(4);
        chk({over_c, under_c}, 32'h0);
        chk(kv, pid_feedback);
        chk(meter, pid_feedback);
        load <= 9'h0b4;
        wt(15);
        load <= 9'h078;
        wt(1);
        load <= 9'h0b4;
        wt(15);
        chk(over_c, 32'h0);
        wt(30);
        chk({over_c, relay1_out, coast_stop}, 32'h6);
        load <= 9'h078;
        wt(5);
        chk({over_c, relay1_out}, 32'h0);
        load <= 9'h014;
        wt(10);
        chk(under_c, 32'h0);
        wt(25);
        chk({under_c, relay2_out, coast_stop}, 32'h6);
        load <= 9'h078;
        wt(5);
        chk(under_c, 32'h0);
        apb(dtc_pkg::OFS_TORQ_CFG, 1'b1, tc(dtc_pkg::DET_AT_SPEED, dtc_pkg::ACT_CONTINUE));
        speed_ok <= 1'b0;
        load <= 9'h0b4;
        wt(50);
        chk(over_c, 32'h0);
        speed_ok <= 1'b1;
        wt(50);
        chk(over_c, 32'h1);
        $display("torque continue tests done");
        apb(dtc_pkg::OFS_TORQ_CFG, 1'b1, tc(dtc_pkg::DET_RUN, dtc_pkg::ACT_COAST));
        for (int k = 0; k < 2; k++) begin
            load <= k ? 9'h014 : 9'h0b4;
            wt(50);
            chk({coast_stop, over_c, under_c}, k ? 32'h5 : 32'h6);
            load <= 9'h078;
            wt(20);
            chk(coast_stop, 32'h1);
            fault_reset <= 1'b1;
            wt(6);
            fault_reset <= 1'b0;
            wt(6);
            chk(coast_stop, 32'h0);
        end
        apb(dtc_pkg::OFS_TORQ_CFG, 1'b1, tc(dtc_pkg::DET_OFF, dtc_pkg::ACT_CONTINUE));
        $display("coast tests done");
        for (int i = 0; i < 20; i++) begin
            bst = (i == 18) ? 9'h190 : (i == 19) ? 9'h000 : 9'($urandom % 301);
            apb(dtc_pkg::OFS_VF_CFG, 1'b1, {15'h0, bst, 3'h0, 5'(i % 18)});
            wt(3);
            chk(vb, PB[i % 18]);
            chk(vc, PC[i % 18]);
            chk(vbst, (i == 18) ? 32'h12c : 32'(bst));
        end
        apb(dtc_pkg::OFS_VF_PTS, 1'b1, {2'h0, 10'h01e, 10'h0c8, 10'h3e8});
        apb(dtc_pkg::OFS_VF_CFG, 1'b1, {27'h0, dtc_pkg::VF_CUSTOM});
        wt(3);
        chk({vb, vc}, {10'h0c8, 10'h01e});
        apb(dtc_pkg::OFS_SLIP_CFG, 1'b1, 32'h0a0a0010);
        load <= 9'h058;
        wt(6);
        chk(slip_freq, slip(88, 16, 160, 10));
        $display("vf tests done");
        apb(dtc_pkg::OFS_PID_GAIN, 1'b1, 32'h01000080);
        for (int k = 0; k < 4; k++) begin
            freq_command <= 16'(2000 + $urandom % 1000);
            wt(1);
            pid_feedback <= freq_command - 16'(50 + $urandom % 100);
            if (k == 3) apb(dtc_pkg::OFS_RELAY_CFG, 1'b1, 32'h000051f5);
            apb(dtc_pkg::OFS_PID_CFG, 1'b1,
                (k == 1) ? 32'h00006417 : (k == 2) ? 32'h00006400 : 32'h00006401);
            wt(25);
            q = pid_exp(k, freq_command, pid_feedback);
            chk(pid_freq_out, q);
        end
        $display("pid tests done");
        end_of_test();
    end
endmodule // dtc_core_tb_top
